//--- hw/flash_seq.sv
// flash erase/program sequencer with wishbone register slave
//
// How it works
// [R01] program writes one 64-instruction row from the latch buffers
// [R02] erase clears a whole page of eight rows, 512 instructions
// [R03] op code 0010 with erase and allow bits set selects page erase
// [R04] op code 0001, erase clear, allow set selects row programming
// [R05] page register gives upper address bits, latch-low write gives lower
// [R06] start honoured only after 55h then AAh written to the key port
// [R07] start bit 15 begins the cycle; core stall held for whole cycle
// [R08] hardware clears start bit when the cycle finishes
// [R09] each latch word loads low 16 bits then upper byte, pointer increments
// [R10] software repeats load and program per row until page restored
// [R11] software places two no-ops after setting the start bit
// [R12] software holds off interrupts around key sequence and start
// [R13] unimplemented op codes perform no flash operation
// [R14] start without fresh key pair or allow bit is ignored
// [R15] unlock is single use; each start attempt consumes it
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module flash_seq (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             coreStall
);


  // ==========================================================================
  // local widths and byte lanes
  localparam int CTL_W      = 16;
  localparam int HALF_W     = 16;
  localparam int BUS_W      = 32;
  localparam int KEY_W      = 8;
  localparam int HI_LSB     = 16;
  localparam int HI_MSB     = flash_seq_pkg::INSTR_W - 1;
  localparam int PAGE_NUM_W = flash_seq_pkg::FLASH_AW - flash_seq_pkg::PAGE_IDX_W;
  localparam int SEL_LO_A   = 0;
  localparam int SEL_LO_B   = 1;
  localparam int SEL_HI     = 2;
  localparam logic [flash_seq_pkg::PAGE_IDX_W-1:0] CNT_ONE  = 9'h001;
  localparam logic [HALF_W-1:0]                   PTR_ONE  = 16'h0001;
  localparam logic [BUS_W-1:0]                    BUS_ZERO = 32'h00000000;

  // ==========================================================================
  // state
  flash_seq_pkg::seq_state_t            stateQ;
  flash_seq_pkg::seq_state_t            stateD;
  flash_seq_pkg::seq_state_t            reqOp;
  flash_seq_pkg::key_state_t            keyQ;
  flash_seq_pkg::key_state_t            keyD;
  logic [CTL_W-1:0]                     ctlQ;
  logic [CTL_W-1:0]                     ctlD;
  logic [flash_seq_pkg::PAGE_IDX_W-1:0] cntQ;
  logic [flash_seq_pkg::PAGE_IDX_W-1:0] cntD;
  logic [HALF_W-1:0]                    pageQ;
  logic [HALF_W-1:0]                    pageD;
  logic [HALF_W-1:0]                    ptrQ;
  logic [HALF_W-1:0]                    ptrD;
  logic [flash_seq_pkg::FLASH_AW-1:0]   targetQ;
  logic [flash_seq_pkg::FLASH_AW-1:0]   targetD;
  logic [flash_seq_pkg::INSTR_W-1:0]    latchQ [0:flash_seq_pkg::ROW_WORDS-1];
  logic [flash_seq_pkg::INSTR_W-1:0]    latchD [0:flash_seq_pkg::ROW_WORDS-1];
  logic                                 ackQ;
  logic                                 ackD;
  logic [BUS_W-1:0]                     datQ;
  logic [BUS_W-1:0]                     datD;

  // ==========================================================================
  // bus strobes and flash port
  logic                                 busReq;
  logic                                 rdReq;
  logic                                 wrStrobe;
  logic                                 wrCtl;
  logic                                 wrKey;
  logic                                 wrPage;
  logic                                 wrLatch;
  logic                                 loSel;
  logic                                 hiSel;
  logic                                 flashErase;
  logic                                 flashWrite;
  logic [flash_seq_pkg::FLASH_AW-1:0]   flashAddr;
  logic [flash_seq_pkg::INSTR_W-1:0]    flashData;
  logic [flash_seq_pkg::INSTR_W-1:0]    flashRd;

  // ==========================================================================
  // decoding helpers
  function automatic logic isAddr(
    input logic [3:0] adr,
    input logic [3:0] target
  );
    isAddr = (adr == target);
  endfunction : isAddr

  // only the two documented codes start anything; all else stays idle
  function automatic flash_seq_pkg::seq_state_t decodeOp(input logic [CTL_W-1:0] ctl);
    logic [flash_seq_pkg::OP_MSB:flash_seq_pkg::OP_LSB] code;
    code     = ctl[flash_seq_pkg::OP_MSB:flash_seq_pkg::OP_LSB];
    decodeOp = flash_seq_pkg::SEQ_IDLE;
    if (ctl[flash_seq_pkg::ALLOW_BIT])
    begin
      if (code == flash_seq_pkg::OP_PAGE_ERASE && ctl[flash_seq_pkg::ERASE_BIT])
        decodeOp = flash_seq_pkg::SEQ_ERASE;     // [R03]
      else if (code == flash_seq_pkg::OP_ROW_PROGRAM && !ctl[flash_seq_pkg::ERASE_BIT])
        decodeOp = flash_seq_pkg::SEQ_PROGRAM;   // [R04]
    end
  endfunction : decodeOp

  // ==========================================================================
  // wishbone strobes: a write lands at the edge where ack is seen high
  assign busReq   = wb_cyc_i && wb_stb_i;
  assign rdReq    = busReq && !wb_we_i && !ackQ;
  assign wrStrobe = busReq && wb_we_i && ackQ;
  assign wrCtl    = wrStrobe && isAddr(wb_adr_i, flash_seq_pkg::ADDR_CONTROL);
  assign wrKey    = wrStrobe && isAddr(wb_adr_i, flash_seq_pkg::ADDR_KEY);
  assign wrPage   = wrStrobe && isAddr(wb_adr_i, flash_seq_pkg::ADDR_PAGE);
  assign wrLatch  = wrStrobe && isAddr(wb_adr_i, flash_seq_pkg::ADDR_LATCH_LO);
  assign loSel    = wb_sel_i[SEL_LO_A] && wb_sel_i[SEL_LO_B];
  assign hiSel    = wb_sel_i[SEL_HI];

  // ==========================================================================
  // control, unlock and sequencer
  always_comb
  begin
    ctlD   = ctlQ;
    keyD   = keyQ;
    stateD = stateQ;
    cntD   = cntQ;
    reqOp  = decodeOp(wb_dat_i[CTL_W-1:0]);
    if (wrKey)
    begin
      if (keyQ == flash_seq_pkg::KEY_NONE && wb_dat_i[KEY_W-1:0] == flash_seq_pkg::KEY_FIRST)
        keyD = flash_seq_pkg::KEY_HALF;    // [R06]
      else if (keyQ == flash_seq_pkg::KEY_HALF
               && wb_dat_i[KEY_W-1:0] == flash_seq_pkg::KEY_SECOND)
        keyD = flash_seq_pkg::KEY_OPEN;    // [R06]
      else
        keyD = flash_seq_pkg::KEY_NONE;
    end
    else if (wrStrobe)
      keyD = flash_seq_pkg::KEY_NONE;      // [R15]
    case (stateQ)
      flash_seq_pkg::SEQ_IDLE:
      begin
        if (wrCtl)
        begin
          ctlD = (ctlQ & ~flash_seq_pkg::CONTROL_WR_MASK)
                 | (wb_dat_i[CTL_W-1:0] & flash_seq_pkg::CONTROL_WR_MASK);
          if (wb_dat_i[flash_seq_pkg::START_BIT])
          begin
            if (keyQ == flash_seq_pkg::KEY_OPEN && reqOp != flash_seq_pkg::SEQ_IDLE)
            begin
              ctlD[flash_seq_pkg::START_BIT] = 1'b1;   // [R07]
              ctlD[flash_seq_pkg::ERR_BIT]   = 1'b0;
              stateD                         = reqOp;
              cntD                           = '0;
            end
            else
              ctlD[flash_seq_pkg::ERR_BIT] = 1'b1;     // [R13] [R14]
          end
        end
      end
      flash_seq_pkg::SEQ_ERASE:
      begin
        if (cntQ == flash_seq_pkg::PAGE_LAST)
        begin
          stateD                         = flash_seq_pkg::SEQ_IDLE;
          ctlD[flash_seq_pkg::START_BIT] = 1'b0;       // [R08]
        end
        else
          cntD = cntQ + CNT_ONE;                       // [R02]
      end
      flash_seq_pkg::SEQ_PROGRAM:
      begin
        if (cntQ[flash_seq_pkg::ROW_IDX_W-1:0] == flash_seq_pkg::ROW_LAST)
        begin
          stateD                         = flash_seq_pkg::SEQ_IDLE;
          ctlD[flash_seq_pkg::START_BIT] = 1'b0;       // [R08]
        end
        else
          cntD = cntQ + CNT_ONE;                       // [R01]
      end
      default:
        stateD = flash_seq_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      stateQ <= flash_seq_pkg::SEQ_IDLE;
      keyQ   <= flash_seq_pkg::KEY_NONE;
      ctlQ   <= flash_seq_pkg::CONTROL_RESET;
      cntQ   <= '0;
    end
    else if (clkEn)
    begin
      stateQ <= stateD;
      keyQ   <= keyD;
      ctlQ   <= ctlD;
      cntQ   <= cntD;
    end
  end

  // core waits for the whole cycle, erase or program
  assign coreStall = (stateQ != flash_seq_pkg::SEQ_IDLE);   // [R07]

  // ==========================================================================
  // page pointer, in-page pointer and target address
  always_comb
  begin
    pageD   = pageQ;
    ptrD    = ptrQ;
    targetD = targetQ;
    if (wrPage)
    begin
      pageD = wb_dat_i[HALF_W-1:0];
      ptrD  = wb_dat_i[BUS_W-1:HALF_W];
    end
    else if (wrLatch)
    begin
      if (loSel)
        targetD = {pageQ[PAGE_NUM_W-1:0], ptrQ[flash_seq_pkg::PAGE_IDX_W-1:0]};   // [R05]
      if (hiSel)
        ptrD = ptrQ + PTR_ONE;   // [R09]
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pageQ   <= '0;
      ptrQ    <= '0;
      targetQ <= '0;
    end
    else if (clkEn)
    begin
      pageQ   <= pageD;
      ptrQ    <= ptrD;
      targetQ <= targetD;
    end
  end

  // ==========================================================================
  // row latches: reset to ones so unloaded words leave cells erased
  generate
    for (genvar w = 0; w < flash_seq_pkg::ROW_WORDS; w++)
    begin : g_latch
      logic hitWord;
      assign hitWord = wrLatch
                       && (ptrQ[flash_seq_pkg::ROW_IDX_W-1:0] == flash_seq_pkg::ROW_IDX_W'(w));
      always_comb
      begin
        latchD[w] = latchQ[w];
        if (hitWord && loSel)
          latchD[w][HALF_W-1:0] = wb_dat_i[HALF_W-1:0];        // [R09]
        if (hitWord && hiSel)
          latchD[w][HI_MSB:HI_LSB] = wb_dat_i[HI_MSB:HI_LSB];  // [R09]
      end
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          latchQ[w] <= '1;
        else if (clkEn)
          latchQ[w] <= latchD[w];
      end
    end
  endgenerate

  // ==========================================================================
  // flash port: idle address is the target, so reads see that word
  assign flashErase = (stateQ == flash_seq_pkg::SEQ_ERASE);
  assign flashWrite = (stateQ == flash_seq_pkg::SEQ_PROGRAM);
  assign flashData  = latchQ[cntQ[flash_seq_pkg::ROW_IDX_W-1:0]];

  always_comb
  begin
    case (stateQ)
      flash_seq_pkg::SEQ_ERASE:
        flashAddr = {targetQ[flash_seq_pkg::FLASH_AW-1:flash_seq_pkg::PAGE_IDX_W], cntQ};
      flash_seq_pkg::SEQ_PROGRAM:
        flashAddr = {targetQ[flash_seq_pkg::FLASH_AW-1:flash_seq_pkg::ROW_IDX_W],
                     cntQ[flash_seq_pkg::ROW_IDX_W-1:0]};
      default:
        flashAddr = targetQ;
    endcase
  end

  flash_array flash_array_i (
    .core_clk (core_clk),
    .clkEn    (clkEn),
    .program_allow_bit     (flashWrite),
    .eraseEn  (flashErase),
    .addr     (flashAddr),
    .wrData   (flashData),
    .rdData   (flashRd)
  );

  // ==========================================================================
  // wishbone answer: one wait state, ack and data registered together
  always_comb
  begin
    ackD = busReq && !ackQ;
    datD = datQ;
    if (rdReq)
    begin
      case (wb_adr_i)
        flash_seq_pkg::ADDR_CONTROL:  datD = {16'h0000, ctlQ};
        flash_seq_pkg::ADDR_PAGE:     datD = {ptrQ, pageQ};
        flash_seq_pkg::ADDR_LATCH_LO: datD = {8'h00, flashRd};
        default:                      datD = BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ackQ <= 1'b0;
      datQ <= '0;
    end
    else if (clkEn)
    begin
      ackQ <= ackD;
      datQ <= datD;
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

endmodule : flash_seq

//--- hw/flash_seq_pkg.sv
// constants, register map and types of the flash erase/program sequencer
package flash_seq_pkg;

  // ==========================================================================
  // register map (byte addresses on the wishbone slave)
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_KEY      = 4'h4;
  localparam logic [3:0] ADDR_PAGE     = 4'h8;
  localparam logic [3:0] ADDR_LATCH_LO = 4'hC;

  // ==========================================================================
  // control register fields
  localparam int OP_LSB    = 0;
  localparam int OP_MSB    = 3;
  localparam int ERASE_BIT = 6;
  localparam int ERR_BIT   = 13;
  localparam int ALLOW_BIT = 14;
  localparam int START_BIT = 15;
  localparam logic [15:0] CONTROL_WR_MASK = 16'h404F;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;

  localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE  = 4'h2;

  // ==========================================================================
  // unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ==========================================================================
  // geometry
  localparam int ROW_WORDS   = 64;
  localparam int PAGE_ROWS   = 8;
  localparam int PAGE_WORDS  = 512;
  localparam int ROW_IDX_W   = 6;
  localparam int PAGE_IDX_W  = 9;
  localparam int FLASH_AW    = 16;
  localparam int INSTR_W     = 24;
  localparam logic [ROW_IDX_W-1:0]  ROW_LAST  = 6'h3F;
  localparam logic [PAGE_IDX_W-1:0] PAGE_LAST = 9'h1FF;

  // ==========================================================================
  // sequencer states and unlock key states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ERASE,
    SEQ_PROGRAM
  } seq_state_t;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_HALF,
    KEY_OPEN
  } key_state_t;

endpackage : flash_seq_pkg

//--- hw/flash_array.sv
// flash cell array model with word write and erase-to-ones
`timescale 1ns/1ps
module flash_array (
  input  wire logic                                   core_clk,
  input  wire logic                                   clkEn,
  input  wire logic                                   program_allow_bit,
  input  wire logic                                   eraseEn,
  input  wire logic [flash_seq_pkg::FLASH_AW-1:0]     addr,
  input  wire logic [flash_seq_pkg::INSTR_W-1:0]      wrData,
  output logic      [flash_seq_pkg::INSTR_W-1:0]      rdData
);

  logic [flash_seq_pkg::INSTR_W-1:0] mem [0:(1<<flash_seq_pkg::FLASH_AW)-1];

  // no reset: flash content survives device reset
  always_ff @(posedge core_clk)
  begin
    if (clkEn)
    begin
      if (eraseEn)
        mem[addr] <= '1;
      else if (program_allow_bit)
        mem[addr] <= mem[addr] & wrData;
      rdData <= mem[addr];
    end
  end

endmodule : flash_array

//--- bench/flash_seq_assertions.sv
// port checker for the flash sequencer
`timescale 1ns/1ps
module flash_seq_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic coreStall
);
  // ==========
  wire logic startWr = wb_cyc_i && wb_we_i && wb_ack_o
    && wb_adr_i == flash_seq_pkg::ADDR_CONTROL && wb_dat_i[flash_seq_pkg::START_BIT];
  wire logic rdCtl = wb_ack_o && !wb_we_i && wb_adr_i == flash_seq_pkg::ADDR_CONTROL;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  stall_cause_a: assert property ($rose(coreStall) |-> $past(startWr))
    else $error("stall without start");
  busy_start_a: assert property (rdCtl && coreStall && $past(coreStall) |-> wb_dat_o[15])
    else $error("start low while busy");
  idle_start_a: assert property (rdCtl && !coreStall && !$past(coreStall) |-> !wb_dat_o[15])
    else $error("start high while idle");
  cover property ($fell(coreStall));
  cover property (startWr ##1 !coreStall);
  ack_has_req_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  stall_ends_a: assert property ($rose(coreStall) |-> ##[1:1000] !coreStall)
    else $error("stall stuck");
  cover property ($rose(coreStall));
endmodule : flash_seq_assertions

//--- bench/core_model.sv
// core stand-in: counts the cycles it is held stalled
`timescale 1ns/1ps
module core_model (
  input  wire logic core_clk,
  input  wire logic coreStall,
  output int        stallCount
);
  initial stallCount = 0;
  always @(posedge core_clk) if (coreStall) stallCount <= stallCount + 1;
endmodule : core_model

//--- bench/flash_seq_test.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
module flash_seq_test;
  logic core_clk = 0, reset = 1, cyc = 0, we = 0, ack, stall;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int err_total = 0, samples_checked = 0, stallCount;
  always #25 core_clk = ~core_clk;
  flash_seq flash_seq_i (.core_clk(core_clk), .reset(reset), .clkEn(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .coreStall(stall));
  core_model core_model_i (.core_clk(core_clk), .coreStall(stall), .stallCount(stallCount));
  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic ok);
    samples_checked++;
    if (!ok) err_total++;
    if (!ok) $display("[FAIL] %0t mismatch", $time);
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge core_clk);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1 && i++ < 3000) @(posedge core_clk);
    check(ack === 1'b1);
    if (ack !== 1'b1) end_of_test();
    rd = rdat;
    cyc <= 1'b0;
  endtask : bus
  // ==========
  // stalls expected only when the key pair is fresh and the request valid
  task automatic op(input logic [15:0] ctl, input logic keys, input logic runs);
    int s, k;
    bus(1'b1, flash_seq_pkg::ADDR_CONTROL, {16'h0000, ctl});
    if (keys) bus(1'b1, flash_seq_pkg::ADDR_KEY, 32'h00000055);
    if (keys) bus(1'b1, flash_seq_pkg::ADDR_KEY, 32'h000000AA);
    s = stallCount;
    bus(1'b1, flash_seq_pkg::ADDR_CONTROL, {16'h0000, ctl | 16'h8000});
    repeat (2) @(posedge core_clk);
    rd = 32'hFFFFFFFF;
    for (k = 0; k < 1000 && rd[15] !== 1'b0; k++) bus(1'b0, flash_seq_pkg::ADDR_CONTROL, 32'h0);
    check(rd[15] === 1'b0);
    check((stallCount != s) == runs);
  endtask : op
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    op(16'h4042, 1'b1, 1'b1);
    bus(1'b0, flash_seq_pkg::ADDR_LATCH_LO, 32'h0);
    check(rd[23:0] === 24'hFFFFFF);
    bus(1'b1, flash_seq_pkg::ADDR_PAGE, 32'h00000000);
    bus(1'b1, flash_seq_pkg::ADDR_LATCH_LO, 32'h00123456);
    bus(1'b0, flash_seq_pkg::ADDR_PAGE, 32'h0);
    check(rd === 32'h00010000);
    op(16'h4001, 1'b1, 1'b1);
    bus(1'b0, flash_seq_pkg::ADDR_LATCH_LO, 32'h0);
    check(rd[23:0] === 24'h123456);
    op(16'h4045, 1'b1, 1'b0);
    op(16'h0042, 1'b1, 1'b0);
    op(16'h4042, 1'b0, 1'b0);
    bus(1'b0, flash_seq_pkg::ADDR_LATCH_LO, 32'h0);
    check(rd[23:0] === 24'h123456);
    end_of_test();
  end
endmodule : flash_seq_test
bind flash_seq flash_seq_assertions flash_seq_assertions_i (.core_clk(core_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .coreStall(coreStall));
